//--- rtl/vdec_cfg_pkg.sv
// Package: register map, field layouts, modes and stream carrier for sync and luma control
package vdec_cfg_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] SUB_SYNC_LOOP  = 8'h08;  // Sync loop configuration
	localparam logic [7:0] SUB_LUMA_PATH  = 8'h09;  // Luma path configuration
	localparam logic [7:0] SYNC_RST_VAL   = 8'h00;  // Sync loop reset value
	localparam logic [7:0] LUMA_RST_VAL   = 8'h00;  // Luma path reset value
	localparam logic [7:0] UNMAPPED_VAL   = 8'h00;  // Read value of any other subaddress

	// ****************************************
	// Serial bus and stream sizing
	// ****************************************
	localparam logic [6:0] DEV_ADDR_DEF   = 7'h21;  // Device address, arbitrary value
	localparam int         FIFO_DEPTH     = 16;     // Luma stream buffer depth

	// ****************************************
	// Decode constants
	// ****************************************
	localparam logic [3:0] SHARP_PLAIN    = 4'h0;   // Plain luma response
	localparam logic [3:0] SHARP_NOTCH    = 4'hd;   // First low-pass code with a notch
	localparam logic [3:0] PEAK_BASE      = 4'h8;   // Peak strength is base minus code
	localparam logic [3:0] LP_STEP        = 4'h1;   // Low-pass level offset
	localparam logic [1:0] DELAY_NTSC     = 2'h1;   // Extra lines for NTSC
	localparam logic [1:0] DELAY_PAL      = 2'h2;   // Extra lines for PAL
	localparam logic [1:0] DELAY_NONE     = 2'h0;   // Pipeline delay only

	// ****************************************
	// Field layouts, MSB first as D7..D0
	// ****************************************
	typedef enum logic [1:0] {
		HL_TV   = 2'b00,
		HL_VTR  = 2'b01,
		HL_RSVD = 2'b10,
		HL_FAST = 2'b11
	} hloop_mode_t;

	typedef enum logic [1:0] {
		VN_NORMAL = 2'b00,
		VN_FAST   = 2'b01,
		VN_FREE   = 2'b10,
		VN_BYPASS = 2'b11
	} vnr_mode_t;

	typedef struct packed {
		logic        auto_field_detect;
		logic        field_rate_select;
		logic        force_field_toggle;
		hloop_mode_t hloop_time_constant;
		logic        hloop_open;
		vnr_mode_t   vertical_noise_mode;
	} sync_cfg_t;

	typedef struct packed {
		logic       trap_comb_bypass;
		logic       adaptive_luma_comb_en;
		logic       extra_line_delay;
		logic       remod_bandwidth_sel;
		logic [3:0] sharpness_select;
	} luma_cfg_t;

	typedef enum logic [1:0] {
		SEP_TRAP   = 2'b00,
		SEP_COMB   = 2'b01,
		SEP_BYPASS = 2'b11
	} luma_sep_t;

	typedef struct packed {
		luma_sep_t  sep;
		logic [7:0] sample;
	} luma_word_t;

	// Serial slave states, Gray along the usual path
	typedef enum logic [3:0] {
		I_IDLE = 4'b0000,
		I_ADDR = 4'b0001,
		I_AACK = 4'b0011,
		I_SUB  = 4'b0010,
		I_SACK = 4'b0110,
		I_WDAT = 4'b0111,
		I_WACK = 4'b0101,
		I_RDAT = 4'b0100,
		I_RACK = 4'b1100
	} i2c_state_t;

endpackage

//--- rtl/stream_fifo.sv
// Module: synchronous valid/ready FIFO for the luma sample stream
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
	logic [AW-1:0]    wp_q;           // Write pointer
	logic [AW-1:0]    rp_q;           // Read pointer
	logic [AW:0]      cnt_q;          // Occupancy
	logic [AW:0]      cnt_d;          // Next occupancy
	logic             ready_q;        // Registered not-full
	logic             push;           // Word accepted
	logic             pop;            // Word drained

	assign push     = wr_valid && ready_q;
	assign pop      = rd_valid && rd_ready;
	assign rd_valid = (cnt_q != '0);
	assign rd_data  = mem_q[rp_q];
	assign wr_ready = ready_q;

	// Occupancy; ready is registered so the source sees a clean flop
	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + (AW+1)'(1);
		else if (pop && !push)
			cnt_d = cnt_q - (AW+1)'(1);
	end

	// Pointers and flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			ready_q <= 1'b1;
		end
		else
		begin
			if (push)
				wp_q <= wp_q + AW'(1);
			if (pop)
				rp_q <= rp_q + AW'(1);
			cnt_q   <= cnt_d;
			ready_q <= (cnt_d < (AW+1)'(DEPTH));
		end
	end

	// Storage has no reset, only written words are ever read
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= wr_data;
	end

endmodule

//--- rtl/sync_luma_ctrl.sv
// Module: sync loop and luma path configuration with serial slave and luma stream
// Contract
// - Auto detect field rate, else forced select
// - Field indicator toggles interlaced, or always forced
// - Time constant picks TV, VTR, fast loop
// - Loop bit opens loop, fixes frequency
// - Noise field picks normal, fast, free, bypass
// - Bypass bit removes trap and comb
// - Comb bit chooses comb over trap
// - Delay bit adds one NTSC, two PAL, none in comb mode
// - Bandwidth bit selects narrow or wide notch
// - Codes one to seven apply decreasing peaking
// - High codes low-pass, top three add notch
`timescale 1ns/10ps
module sync_luma_ctrl
	import vdec_cfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  scl_i,
	input  wire logic  sda_i,
	output logic       sda_o,
	output logic       sda_oe,
	input  wire logic  det_field_60,
	input  wire logic  src_interlaced,
	input  wire logic  field_start,
	input  wire logic  std_pal,
	input  wire logic  [7:0] y_in,
	input  wire logic  y_in_valid,
	output logic       y_in_ready,
	output luma_word_t y_out,
	output logic       y_out_valid,
	input  wire logic  y_out_ready,
	output logic       field_60hz,
	output logic       odd_even,
	output hloop_mode_t hloop_mode,
	output logic       hloop_closed,
	output vnr_mode_t  vnr_mode,
	output luma_sep_t  luma_sep,
	output logic [1:0] extra_delay_lines,
	output logic       notch_wide,
	output logic [2:0] peak_level,
	output logic [3:0] lowpass_level,
	output logic       lp_notch_en
);

	// ****************************************
	// Pin synchronisers and edge detect
	// ****************************************
	logic scl_s1_q, scl_s2_q, scl_s3_q;  // Clock pin stages
	logic sda_s1_q, sda_s2_q, sda_s3_q;  // Data pin stages
	logic scl_rise, scl_fall;            // Clock edges
	logic bus_start, bus_stop;           // Bus conditions

	// Two flops per pin, third stage only for edges of the settled value
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end
		else
		begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	assign scl_rise  = scl_s2_q && !scl_s3_q;
	assign scl_fall  = !scl_s2_q && scl_s3_q;
	assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
	assign bus_stop  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

	// ****************************************
	// Serial slave
	// ****************************************
	i2c_state_t st_q;       // Slave state
	logic [2:0] cnt_q;      // Bit count within a byte
	logic       done_q;     // Eight bits seen
	logic [7:0] shift_q;    // Shift register
	logic [7:0] sub_q;      // Subaddress pointer
	logic       rw_q;       // Read transfer
	logic       ack_ok_q;   // Master acknowledged read byte
	logic       oe_q;       // Pulling data low
	logic [7:0] rd_cur;     // Read value at pointer
	logic [7:0] rd_nxt;     // Read value at pointer plus one
	logic       wr_en;      // Data byte complete

	sync_cfg_t  sync_q;     // Sync loop configuration
	luma_cfg_t  luma_q;     // Luma path configuration

	// Register read mux; unmapped subaddresses read fixed zero
	function automatic logic [7:0] rd_byte(input logic [7:0] a, input sync_cfg_t s,
		input luma_cfg_t l);
		case (a)
			SUB_SYNC_LOOP: rd_byte = s;
			SUB_LUMA_PATH: rd_byte = l;
			default:       rd_byte = UNMAPPED_VAL;
		endcase
	endfunction

	assign rd_cur = rd_byte(sub_q, sync_q, luma_q);
	assign rd_nxt = rd_byte(sub_q + 8'h01, sync_q, luma_q);
	assign wr_en  = scl_fall && (st_q == I_WDAT) && done_q;

	// Bit level protocol; start and stop win over any edge in progress
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q     <= I_IDLE;
			cnt_q    <= 3'h0;
			done_q   <= 1'b0;
			shift_q  <= 8'h00;
			sub_q    <= 8'h00;
			rw_q     <= 1'b0;
			ack_ok_q <= 1'b0;
			oe_q     <= 1'b0;
		end
		else if (bus_start)
		begin
			st_q   <= I_ADDR;
			cnt_q  <= 3'h0;
			done_q <= 1'b0;
			oe_q   <= 1'b0;
		end
		else if (bus_stop)
		begin
			st_q   <= I_IDLE;
			done_q <= 1'b0;
			oe_q   <= 1'b0;
		end
		else if (scl_rise)
		begin
			case (st_q)
				I_ADDR, I_SUB, I_WDAT:
				begin
					shift_q <= {shift_q[6:0], sda_s2_q};
					cnt_q   <= cnt_q + 3'h1;
					done_q  <= (cnt_q == 3'h7);
				end
				I_RDAT:
				begin
					cnt_q  <= cnt_q + 3'h1;
					done_q <= (cnt_q == 3'h7);
				end
				I_RACK:
					ack_ok_q <= !sda_s2_q;
				default:
					;
			endcase
		end
		else if (scl_fall)
		begin
			case (st_q)
				I_ADDR:
					if (done_q)
					begin
						done_q <= 1'b0;
						if (shift_q[7:1] == DEV_ADDR)
						begin
							st_q <= I_AACK;
							oe_q <= 1'b1;
							rw_q <= shift_q[0];
						end
						else
							st_q <= I_IDLE;
					end
				I_AACK:
					if (rw_q)
					begin
						st_q    <= I_RDAT;
						shift_q <= rd_cur;
						oe_q    <= !rd_cur[7];
					end
					else
					begin
						st_q <= I_SUB;
						oe_q <= 1'b0;
					end
				I_SUB:
					if (done_q)
					begin
						sub_q  <= shift_q;
						st_q   <= I_SACK;
						oe_q   <= 1'b1;
						done_q <= 1'b0;
					end
				I_SACK:
				begin
					st_q <= I_WDAT;
					oe_q <= 1'b0;
				end
				I_WDAT:
					if (done_q)
					begin
						st_q   <= I_WACK;
						oe_q   <= 1'b1;
						done_q <= 1'b0;
					end
				I_WACK:
				begin
					// Auto increment for burst writes
					st_q  <= I_WDAT;
					oe_q  <= 1'b0;
					sub_q <= sub_q + 8'h01;
				end
				I_RDAT:
					if (done_q)
					begin
						st_q   <= I_RACK;
						oe_q   <= 1'b0;
						done_q <= 1'b0;
					end
					else
					begin
						shift_q <= {shift_q[6:0], 1'b0};
						oe_q    <= !shift_q[6];
					end
				I_RACK:
					if (ack_ok_q)
					begin
						sub_q   <= sub_q + 8'h01;
						st_q    <= I_RDAT;
						shift_q <= rd_nxt;
						oe_q    <= !rd_nxt[7];
					end
					else
						st_q <= I_IDLE;
				default:
					st_q <= I_IDLE;
			endcase
		end
	end

	// Open-drain pin, only ever pulled low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sda_o  <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			sda_o  <= 1'b0;
			sda_oe <= oe_q;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// Codes software should not use are stored as written; decode copes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_q <= SYNC_RST_VAL;
			luma_q <= LUMA_RST_VAL;
		end
		else if (wr_en)
		begin
			if (sub_q == SUB_SYNC_LOOP)
				sync_q <= shift_q;
			if (sub_q == SUB_LUMA_PATH)
				luma_q <= shift_q;
		end
	end

	// ****************************************
	// Sync loop decode
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			field_60hz   <= 1'b0;
			hloop_mode   <= HL_FAST;
			hloop_closed <= 1'b1;
			vnr_mode     <= VN_NORMAL;
		end
		else
		begin
			// Detector result or forced rate
			field_60hz <= sync_q.auto_field_detect ? det_field_60
				: sync_q.field_rate_select;
			// Reserved code falls back to the fast locking loop
			hloop_mode <= (sync_q.hloop_time_constant == HL_RSVD) ? HL_FAST
				: sync_q.hloop_time_constant;
			hloop_closed <= !sync_q.hloop_open;
			vnr_mode     <= sync_q.vertical_noise_mode;
		end
	end

	// Field indicator; a non-interlaced source holds it unless forced
	always_ff @(posedge clk)
	begin
		if (rst)
			odd_even <= 1'b0;
		else if (field_start && (src_interlaced || sync_q.force_field_toggle))
			odd_even <= !odd_even;
	end

	// ****************************************
	// Luma path decode
	// ****************************************
	luma_sep_t sep_d;  // Current separation choice

	always_comb
	begin
		if (luma_q.trap_comb_bypass)
			sep_d = SEP_BYPASS;
		else if (luma_q.adaptive_luma_comb_en)
			sep_d = SEP_COMB;
		else
			sep_d = SEP_TRAP;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			luma_sep          <= SEP_TRAP;
			extra_delay_lines <= DELAY_NONE;
			notch_wide        <= 1'b0;
			peak_level        <= 3'h0;
			lowpass_level     <= 4'h0;
			lp_notch_en       <= 1'b0;
		end
		else
		begin
			luma_sep <= sep_d;
			// Comb mode carries its own line memory delay
			if (luma_q.extra_line_delay && sep_d != SEP_COMB)
				extra_delay_lines <= std_pal ? DELAY_PAL : DELAY_NTSC;
			else
				extra_delay_lines <= DELAY_NONE;
			notch_wide <= luma_q.remod_bandwidth_sel;
			// Peak 7 is the strongest boost, 1 the weakest
			if (!luma_q.sharpness_select[3] && luma_q.sharpness_select != SHARP_PLAIN)
				peak_level <= 3'(PEAK_BASE - luma_q.sharpness_select);
			else
				peak_level <= 3'h0;
			// Low-pass 1 is mildest, 8 the narrowest
			if (luma_q.sharpness_select[3])
				lowpass_level <= {1'b0, luma_q.sharpness_select[2:0]} + LP_STEP;
			else
				lowpass_level <= 4'h0;
			lp_notch_en <= (luma_q.sharpness_select >= SHARP_NOTCH);
		end
	end

	// ****************************************
	// Luma stream buffer
	// ****************************************
	luma_word_t fifo_out;    // Head of buffer
	logic       fifo_valid;  // Buffer not empty
	logic       fifo_take;   // Output stage accepts

	// Each sample is tagged with the path it was taken under
	stream_fifo #(
		.WIDTH ($bits(luma_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.wr_data  ({sep_d, y_in}),
		.wr_valid (y_in_valid),
		.wr_ready (y_in_ready),
		.rd_data  (fifo_out),
		.rd_valid (fifo_valid),
		.rd_ready (fifo_take)
	);

	assign fifo_take = !y_out_valid || y_out_ready;

	// Output register stage so the sink sees flops only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			y_out_valid <= 1'b0;
			y_out       <= '0;
		end
		else if (fifo_take)
		begin
			y_out_valid <= fifo_valid;
			if (fifo_valid)
				y_out <= fifo_out;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_byte_end;
		scl_fall && st_q == I_WDAT && done_q;
	endsequence

	sequence s_ack_drive;
		st_q == I_WACK && oe_q ##1 sda_oe;
	endsequence

	a_field_rate_sel: assert property (##1 field_60hz == ($past(sync_q.auto_field_detect)
		? $past(det_field_60) : $past(sync_q.field_rate_select)))
		else $error("field rate not from selected source");
	a_toggle_hold: assert property (field_start && !src_interlaced
		&& !sync_q.force_field_toggle |=> $stable(odd_even))
		else $error("indicator toggled for progressive source");
	a_toggle_flip: assert property ((field_start && (src_interlaced
		|| sync_q.force_field_toggle)) |=> odd_even != $past(odd_even))
		else $error("indicator failed to toggle");
	a_hloop_code: assert property (##1 hloop_mode != HL_RSVD)
		else $error("reserved loop code reached the loop");
	a_hloop_open: assert property (sync_q.hloop_open ##1 sync_q.hloop_open
		|-> !hloop_closed)
		else $error("loop closed while open requested");
	a_vnr_follow: assert property (##1 vnr_mode == $past(sync_q.vertical_noise_mode))
		else $error("noise mode mismatch");
	a_bypass_path: assert property (luma_q.trap_comb_bypass |=> luma_sep == SEP_BYPASS)
		else $error("bypass not applied");
	a_comb_path: assert property (!luma_q.trap_comb_bypass && luma_q.adaptive_luma_comb_en
		|=> luma_sep == SEP_COMB)
		else $error("comb not selected");
	a_line_delay: assert property (luma_q.extra_line_delay && !luma_q.adaptive_luma_comb_en
		&& std_pal |=> extra_delay_lines == DELAY_PAL)
		else $error("PAL extra delay wrong");
	a_notch_width: assert property (##1 notch_wide == $past(luma_q.remod_bandwidth_sel))
		else $error("notch width mismatch");
	a_peak_range: assert property (luma_q.sharpness_select == 4'h1 |=> peak_level == 3'h7)
		else $error("strongest peaking wrong");
	a_lowpass_top: assert property (luma_q.sharpness_select == 4'hf
		|=> lowpass_level == 4'h8 && lp_notch_en && peak_level == 3'h0)
		else $error("top low-pass code wrong");
	a_write_ack: assert property (s_byte_end |=> s_ack_drive)
		else $error("written byte not acknowledged");

endmodule

//--- dv/cfg_host.sv
// Host controller model that drives the serial configuration bus
`timescale 1ns/10ps
module cfg_host
	import vdec_cfg_pkg::*;
(
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_m
);
	// ****************************************
	// Bus phases
	// ****************************************
	localparam int HALF = 10;  // Clocks per phase, above the slave minimum of 8

	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Data moves only while scl is low, so it never reads as start or stop
	task automatic bit_io(input logic b, output logic r);
		wt(2);
		sda_m = b;
		wt(HALF);
		scl = 1'b1;
		wt(HALF);
		r = sda_w;
		scl = 1'b0;
	endtask

	// Start from idle or as a repeated start
	task automatic start_c;
		sda_m = 1'b1;
		wt(HALF);
		scl = 1'b1;
		wt(HALF);
		sda_m = 1'b0;
		wt(HALF);
		scl = 1'b0;
	endtask

	task automatic stop_c;
		wt(2);
		sda_m = 1'b0;
		wt(HALF);
		scl = 1'b1;
		wt(HALF);
		sda_m = 1'b1;
		wt(HALF);
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
		output logic acked);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(rel, a);
		acked = !a;
	endtask

	// Host software never asks for the reserved or TV time constant, nor fast noise mode with auto field detect
	function automatic logic sync_ok(input logic [7:0] d);
		return d[4:3] != 2'b10 && d[4:3] != 2'b00 && !(d[1:0] == 2'b01 && d[7]);
	endfunction

	// Write n data bytes from sub; ok is the AND of the address, subaddress and first data slots
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] sub,
		input logic [7:0] d0, input logic [7:0] d1, input int n, output logic ok);
		logic [7:0] rx;
		logic a;
		ok = 1'b0;
		if (sub == SUB_SYNC_LOOP && !sync_ok(d0))
			return;
		start_c();
		byte_io({dev, 1'b0}, 1'b1, rx, ok);
		byte_io(sub, 1'b1, rx, a);
		ok = ok & a;
		byte_io(d0, 1'b1, rx, a);
		ok = ok & a;
		if (n > 1)
			byte_io(d1, 1'b1, rx, a);
		stop_c();
	endtask

	// Set pointer, repeated start, read n bytes, NACK on the last
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] sub, input int n,
		output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] rx;
		logic a;
		start_c();
		byte_io({dev, 1'b0}, 1'b1, rx, a);
		byte_io(sub, 1'b1, rx, a);
		start_c();
		byte_io({dev, 1'b1}, 1'b1, rx, a);
		byte_io(8'hff, n == 1, r0, a);
		r1 = 8'h00;
		if (n > 1)
			byte_io(8'hff, 1'b1, r1, a);
		stop_c();
	endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the sync and luma configuration block
`timescale 1ns/10ps
module testbench
	import vdec_cfg_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk, rst, scl, sda_m, sda_oe, ok, sda_lvl;
	logic        det_field_60, src_interlaced, field_start, std_pal;
	logic [7:0]  y_in, r0, r1;
	logic        y_in_valid, y_in_ready, y_out_valid, y_out_ready;
	luma_word_t  y_out;
	logic        field_60hz, odd_even, hloop_closed, notch_wide, lp_notch_en, oe;
	hloop_mode_t hloop_mode;
	vnr_mode_t   vnr_mode;
	luma_sep_t   luma_sep;
	logic [1:0]  extra_delay_lines, es, ed;
	logic [2:0]  peak_level;
	logic [3:0]  lowpass_level;
	logic [7:0]  d;
	int          bad_count, n_tests, cycles, acc, got;
	wire logic   sda_w;
	logic [7:0]  sync_tab [4] = '{8'h98, 8'h4d, 8'h3a, 8'hff};  // Legal sync settings

	assign sda_w = sda_m & !sda_oe;  // Open drain with pull-up

	sync_luma_ctrl sync_luma_ctrl_i (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_lvl), .sda_oe(sda_oe), .det_field_60(det_field_60),
		.src_interlaced(src_interlaced), .field_start(field_start), .std_pal(std_pal),
		.y_in(y_in), .y_in_valid(y_in_valid), .y_in_ready(y_in_ready), .y_out(y_out),
		.y_out_valid(y_out_valid), .y_out_ready(y_out_ready), .field_60hz(field_60hz),
		.odd_even(odd_even), .hloop_mode(hloop_mode), .hloop_closed(hloop_closed),
		.vnr_mode(vnr_mode), .luma_sep(luma_sep), .extra_delay_lines(extra_delay_lines),
		.notch_wide(notch_wide), .peak_level(peak_level), .lowpass_level(lowpass_level),
		.lp_notch_en(lp_notch_en));
	cfg_host cfg_host_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

	always #5 clk = ~clk;

	// Hang guard, far above the roughly 25k cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			bad_count++;
			conclude();
		end
	end

	// ****************************************
	// Check helpers
	// ****************************************
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got_v);
		n_tests++;
		if (got_v !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got_v);
		end
	endtask

	task automatic pulse_field;
		@(negedge clk) field_start = 1'b1;
		@(negedge clk) field_start = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		{det_field_60, src_interlaced, field_start, std_pal} = 4'h0;
		{y_in, y_in_valid, y_out_ready} = 10'h000;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		// Reset values, two-byte read checks auto-increment
		cfg_host_i.read_reg(DEV_ADDR_DEF, SUB_SYNC_LOOP, 2, r0, r1);
		chk("sync reset", SYNC_RST_VAL, r0);
		chk("luma reset", LUMA_RST_VAL, r1);
		chk("hloop reset", HL_TV, hloop_mode);
		chk("closed reset", 8'h01, hloop_closed);
		// Unmapped place accepts and reads zero
		cfg_host_i.write_reg(DEV_ADDR_DEF, 8'h0a, 8'h5a, 8'h00, 1, ok);
		chk("unmapped ack", 8'h01, ok);
		cfg_host_i.read_reg(DEV_ADDR_DEF, 8'h0a, 1, r0, r1);
		chk("unmapped", UNMAPPED_VAL, r0);
		// Foreign address is ignored
		cfg_host_i.write_reg(DEV_ADDR_DEF ^ 7'h01, SUB_SYNC_LOOP, 8'h98, 8'h00, 1, ok);
		chk("foreign ack", 8'h00, ok);
		cfg_host_i.read_reg(DEV_ADDR_DEF, SUB_SYNC_LOOP, 1, r0, r1);
		chk("foreign write", SYNC_RST_VAL, r0);
		// Sync settings with field detect and indicator
		foreach (sync_tab[i])
		begin
			d = sync_tab[i];
			cfg_host_i.write_reg(DEV_ADDR_DEF, SUB_SYNC_LOOP, d, 8'h00, 1, ok);
			chk("sync write ack", 8'h01, ok);
			cfg_host_i.read_reg(DEV_ADDR_DEF, SUB_SYNC_LOOP, 1, r0, r1);
			chk("sync read", d, r0);
			chk("hloop mode", d[4:3], hloop_mode);
			chk("hloop closed", !d[2], hloop_closed);
			chk("vnr mode", d[1:0], vnr_mode);
			det_field_60 = !d[6];
			src_interlaced = 1'b0;
			oe = odd_even;
			pulse_field();
			chk("field rate", d[7] ? !d[6] : d[6], field_60hz);
			chk("indicator progressive", oe ^ d[5], odd_even);
			src_interlaced = 1'b1;
			pulse_field();
			chk("indicator interlaced", !(oe ^ d[5]), odd_even);
		end
		// Every sharpness code, each with its inverted code in the upper bits
		for (int i = 0; i < 16; i++)
		begin
			d = {~4'(i), 4'(i)};
			std_pal = d[0];
			cfg_host_i.write_reg(DEV_ADDR_DEF, SUB_LUMA_PATH, d, 8'h00, 1, ok);
			chk("luma write ack", 8'h01, ok);
			es = d[7] ? SEP_BYPASS : (d[6] ? SEP_COMB : SEP_TRAP);
			ed = (d[5] && es != SEP_COMB) ? (d[0] ? DELAY_PAL : DELAY_NTSC) : DELAY_NONE;
			chk("separation", es, luma_sep);
			chk("extra delay", ed, extra_delay_lines);
			chk("notch wide", d[4], notch_wide);
			chk("peak", (i >= 1 && i <= 7) ? 8'(PEAK_BASE - 4'(i)) : 8'h00, peak_level);
			chk("lowpass", (i >= 8) ? 8'(4'(i) - 4'h7) : 8'h00, lowpass_level);
			chk("lp notch", 4'(i) >= SHARP_NOTCH, lp_notch_en);
		end
		// Stream: fill with sink stalled, then retune and drain with stalls
		cfg_host_i.write_reg(DEV_ADDR_DEF, SUB_LUMA_PATH, 8'h40, 8'h00, 1, ok);
		acc = 0;
		for (int k = 0; k < 30; k++)
		begin
			@(negedge clk);
			y_in_valid = 1'b1;
			y_in = 8'h30 + 8'(acc);
			if (y_in_ready === 1'b1)
				acc++;
		end
		@(negedge clk) y_in_valid = 1'b0;
		chk("fill count", 8'(FIFO_DEPTH + 1), 8'(acc));
		chk("full ready", 8'h00, y_in_ready);
		cfg_host_i.write_reg(DEV_ADDR_DEF, SUB_LUMA_PATH, 8'h80, 8'h00, 1, ok);
		got = 0;
		for (int k = 0; k < 200 && got < acc; k++)
		begin
			@(negedge clk);
			y_out_ready = k[0];
			if (y_out_ready && y_out_valid === 1'b1)
			begin
				chk("stream sample", 8'h30 + 8'(got), y_out.sample);
				chk("stream tag", SEP_COMB, y_out.sep);
				got++;
			end
		end
		@(negedge clk) y_out_ready = 1'b0;
		repeat (3) @(negedge clk);
		chk("drained", 8'(acc), 8'(got));
		chk("empty valid", 8'h00, y_out_valid);
		chk("bypass now", SEP_BYPASS, luma_sep);
		chk("sda level", 8'h00, sda_lvl);
		// Mid-run reset with the bus idle must restore both registers
		@(negedge clk) rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		cfg_host_i.read_reg(DEV_ADDR_DEF, SUB_SYNC_LOOP, 2, r0, r1);
		chk("sync after reset", SYNC_RST_VAL, r0);
		chk("luma after reset", LUMA_RST_VAL, r1);
		chk("trap after reset", SEP_TRAP, luma_sep);
		chk("hloop after reset", HL_TV, hloop_mode);
		conclude();
	end
endmodule
